/* File: reset_checker_props.sv */
// checker: timing relations of the reset sequencer ports
`timescale 1ns/10ps
`default_nettype none
module reset_checker
  import rst_seq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic watchdog_reset_mode,
  input wire logic watchdog_overflow_reset,
  input wire logic low_voltage_reset_event,
  input wire logic clock_monitor_reset_event,
  input wire logic [7:0] cause_flags_clear_mask,
  input wire logic cause_flags_clear_we,
  input wire logic system_reset,
  input wire clk_ctrl_t clk_ctrl,
  input wire logic [2:0] cpu_clk_div,
  input wire logic cpu_start,
  input wire logic [31:0] cpu_fetch_addr,
  input wire logic watchdog_run,
  input wire logic [WDT_WIDTH-1:0] watchdog_count,
  input wire logic io_output_enable,
  input wire logic [7:0] debug_mode_control,
  input wire logic [7:0] reset_cause_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // output values in reset, stabilization and run, and watchdog counting
  clocks_stop_a: assert property (
    system_reset |-> clk_ctrl == 5'h04)
    else $error("clock enables wrong in reset");
  stab_clocks_a: assert property (
    !system_reset && !cpu_start |-> clk_ctrl == 5'h1C && !io_output_enable)
    else $error("clocks live before stabilization");
  io_hiz_a: assert property (system_reset |-> !io_output_enable &&
    !cpu_start && cpu_clk_div == 3'h3) else $error("outputs live in reset");
  wdt_clear_a: assert property (system_reset |-> watchdog_count == 16'h0)
    else $error("watchdog count not cleared");
  wdt_count_a: assert property (watchdog_run && $past(watchdog_run) |->
    watchdog_count == $past(watchdog_count) + 16'h1) else $error("count step");
  fetch_zero_a: assert property (
    cpu_start |-> cpu_fetch_addr == 32'h0 && clk_ctrl == 5'h1F &&
    io_output_enable) else $error("run outputs wrong");
  ////////////////////////////////////////////////////////////////////////
  // pin reset entry and initial values
  pin_entry_a: assert property (
    (!reset_pin_n)[*6] |-> system_reset)
    else $error("pin low without reset");
  pin_init_a: assert property ((!reset_pin_n)[*8] |->
    debug_mode_control == 8'h01 && reset_cause_flags == 8'h00)
    else $error("pin reset values wrong");
  ////////////////////////////////////////////////////////////////////////
  // watchdog reset and cause flags
  wdt_entry_a: assert property (reset_pin_n[*6] ##0 (cpu_start &&
    watchdog_reset_mode && watchdog_overflow_reset) |-> ##[1:2]
    (system_reset && reset_cause_flags[4])) else $error("no watchdog reset");
  wdt_keep_a: assert property (reset_pin_n[*6] ##0 (cpu_start &&
    watchdog_reset_mode && watchdog_overflow_reset) |=>
    $stable(debug_mode_control)[*4]) else $error("debug control changed");
  flag_clear_a: assert property (
    reset_pin_n[*6] ##0 (cause_flags_clear_we &&
    !system_reset && !low_voltage_reset_event && !clock_monitor_reset_event
    && !watchdog_overflow_reset) |=> reset_cause_flags ==
    ($past(reset_cause_flags) & $past(cause_flags_clear_mask)))
    else $error("flag clear wrong");
endmodule // reset_checker
bind system_reset_pin_and_watchdog reset_checker chk_i (.*);
`default_nettype wire

/* File: reset_source.sv */
// partner: external reset source driving the reset pin
`timescale 1ns/10ps
`default_nettype none
module reset_source (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] low_cyc,
  output logic reset_pin_n
);
  logic [7:0] left_q = 8'h00;
  // counts down the low time of one requested pulse
  always @(posedge clk) begin
    if (go) left_q <= low_cyc;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  assign reset_pin_n = (left_q == 8'h00); // pulled up when released
endmodule // reset_source
`default_nettype wire

/* File: rst_seq_pkg.sv */
// package: constants and carrier types for the system reset sequencer
package rst_seq_pkg;

  // clock rate and derived cycle counts
  localparam int CLK_PERIOD_NS = 40;
  localparam int PIN_FILTER_NS = 60;
  localparam int PIN_FILTER_CYC =
    (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_RST_HOLD_CYC = 16;
  localparam int OSC_STAB_CYC = 1024;
  localparam int WDT_WIDTH = 16;

  // reset values
  localparam logic [7:0] DEBUG_CTRL_PIN_RESET = 8'h01;
  localparam logic [7:0] CAUSE_FLAGS_PIN_RESET = 8'h00;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [2:0] CPU_DIV_RESET = 3'h3; // divide by eight

  // reset cause flag positions
  localparam int LOW_VOLTAGE_RESET_FLAG_BIT = 0;
  localparam int CLOCK_MONITOR_RESET_FLAG_BIT = 1;
  localparam int WATCHDOG_RESET_FLAG_BIT = 4;

  // sequencer phases
  typedef enum logic [1:0] {
    PH_PIN_RESET,
    PH_WDT_RESET,
    PH_STABILIZE,
    PH_RUN
  } phase_t;

  // clock enables handed to the clock tree
  typedef struct packed {
    logic main_osc_run;
    logic int_osc_run;
    logic sub_osc_run;
    logic periph_clk_run;
    logic cpu_clk_run;
  } clk_ctrl_t;

endpackage : rst_seq_pkg

/* File: system_reset_pin_and_watchdog.sv */
// module: system reset sequencer for pin and watchdog reset sources
`timescale 1ns/10ps
`default_nettype none

// Contract
// - pin held low keeps whole system in reset, all units initialized
// - pin returning high ends the pin reset state
// - pin input filtered about 60 ns against short noise pulses
// - main and internal oscillators stop in reset; subclock keeps running
// - peripheral clocks halted until stabilization time counted after release
// - system and cpu clocks stop; restart with cpu divider at eight
// - after stabilization following pin reset, cpu fetches from address zero
// - watchdog stopped and cleared in reset, counts up from zero after
// - ram kept across reset except power-on or access collision
// - all port lines high impedance during reset
// - pin reset initializes registers and sets debug control to 01H
// - watchdog reset initializes registers, debug control kept
// - watchdog overflow in reset mode asserts full system reset
// - watchdog reset lasts fixed delay then releases by itself
// - main oscillator held stopped through watchdog reset
// - pin reset clears cause flags; other sources set own flag only
// - software may only clear flags; set wins over clear
module system_reset_pin_and_watchdog
  import rst_seq_pkg::*;
#(
  parameter int FILTER_CYC = PIN_FILTER_CYC,
  parameter int WDT_HOLD_CYC = WDT_RST_HOLD_CYC,
  parameter int STAB_CYC = OSC_STAB_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic watchdog_reset_mode,
  input wire logic watchdog_overflow_reset,
  input wire logic low_voltage_reset_event,
  input wire logic clock_monitor_reset_event,
  input wire logic cpu_access_active,
  input wire logic [7:0] cause_flags_clear_mask,
  input wire logic cause_flags_clear_we,
  input wire logic debug_mode_enable_clear,
  output logic system_reset,
  output clk_ctrl_t clk_ctrl,
  output logic [2:0] cpu_clk_div,
  output logic cpu_start,
  output logic [31:0] cpu_fetch_addr,
  output logic watchdog_run,
  output logic [WDT_WIDTH-1:0] watchdog_count,
  output logic ram_contents_valid,
  output logic io_output_enable,
  output logic [7:0] debug_mode_control,
  output logic [7:0] reset_cause_flags
);

  localparam int FW = $clog2(FILTER_CYC + 1);
  localparam int HW = $clog2(WDT_HOLD_CYC + 1);
  localparam int SW = $clog2(STAB_CYC + 1);

  //////////////////////////////////////////////////////////////////////////
  // pin synchroniser and noise filter
  logic pin_meta_q, pin_meta_d;
  logic pin_sync_q, pin_sync_d;
  logic pin_filt_q, pin_filt_d;
  logic [FW-1:0] filt_cnt_q, filt_cnt_d;

  // filtered level only follows after FILTER_CYC stable samples
  always_comb begin
    pin_meta_d = reset_pin_n;
    pin_sync_d = pin_meta_q;
    pin_filt_d = pin_filt_q;
    filt_cnt_d = '0;
    if (pin_sync_q != pin_filt_q) begin
      if (filt_cnt_q == FW'(FILTER_CYC - 1)) begin
        pin_filt_d = pin_sync_q;
      end else begin
        filt_cnt_d = filt_cnt_q + FW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_filt_q <= 1'b0;
      filt_cnt_q <= '0;
    end else begin
      pin_meta_q <= pin_meta_d;
      pin_sync_q <= pin_sync_d;
      pin_filt_q <= pin_filt_d;
      filt_cnt_q <= filt_cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset sequencer
  phase_t phase_q, phase_d;
  logic [HW-1:0] hold_cnt_q, hold_cnt_d;
  logic [SW-1:0] stab_cnt_q, stab_cnt_d;
  logic pin_low;
  logic wdt_fire;
  logic in_reset;

  assign pin_low = !pin_filt_q;
  assign wdt_fire = watchdog_reset_mode && watchdog_overflow_reset;

  // pin reset outranks watchdog; watchdog hold ends by itself
  always_comb begin
    phase_d = phase_q;
    hold_cnt_d = hold_cnt_q;
    stab_cnt_d = stab_cnt_q;
    if (pin_low) begin
      phase_d = PH_PIN_RESET;
      stab_cnt_d = '0;
    end else begin
      unique case (phase_q)
        PH_PIN_RESET: begin
          phase_d = PH_STABILIZE;
          stab_cnt_d = '0;
        end
        PH_WDT_RESET: begin
          if (hold_cnt_q == HW'(WDT_HOLD_CYC - 1)) begin
            phase_d = PH_STABILIZE;
            stab_cnt_d = '0;
          end else begin
            hold_cnt_d = hold_cnt_q + HW'(1);
          end
        end
        PH_STABILIZE: begin
          if (wdt_fire) begin
            phase_d = PH_WDT_RESET;
            hold_cnt_d = '0;
          end else if (stab_cnt_q == SW'(STAB_CYC - 1)) begin
            phase_d = PH_RUN;
          end else begin
            stab_cnt_d = stab_cnt_q + SW'(1);
          end
        end
        PH_RUN: begin
          if (wdt_fire) begin
            phase_d = PH_WDT_RESET;
            hold_cnt_d = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= PH_PIN_RESET;
      hold_cnt_q <= '0;
      stab_cnt_q <= '0;
    end else begin
      phase_q <= phase_d;
      hold_cnt_q <= hold_cnt_d;
      stab_cnt_q <= stab_cnt_d;
    end
  end

  // one merged system reset for both sources
  assign in_reset = (phase_q == PH_PIN_RESET) ||
                    (phase_q == PH_WDT_RESET);

  //////////////////////////////////////////////////////////////////////////
  // clock and cpu control outputs, registered; fetch address is the constant RESET_VECTOR
  logic sys_rst_q, sys_rst_d;
  clk_ctrl_t clk_q, clk_d;
  logic [2:0] div_q, div_d;
  logic start_q, start_d;
  logic io_oe_q, io_oe_d;

  always_comb begin
    sys_rst_d = (phase_d == PH_PIN_RESET) ||
                (phase_d == PH_WDT_RESET);
    clk_d.sub_osc_run = 1'b1;
    clk_d.main_osc_run = !sys_rst_d;
    clk_d.int_osc_run = !sys_rst_d;
    clk_d.periph_clk_run = (phase_d == PH_RUN);
    clk_d.cpu_clk_run = (phase_d == PH_RUN);
    div_d = sys_rst_d ? CPU_DIV_RESET : div_q;
    start_d = (phase_d == PH_RUN);
    io_oe_d = (phase_d == PH_RUN);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sys_rst_q <= 1'b1;
      clk_q <= '{main_osc_run: 1'b0, int_osc_run: 1'b0, sub_osc_run: 1'b1,
                 periph_clk_run: 1'b0, cpu_clk_run: 1'b0};
      div_q <= CPU_DIV_RESET;
      start_q <= 1'b0;
      io_oe_q <= 1'b0;
    end else begin
      sys_rst_q <= sys_rst_d;
      clk_q <= clk_d;
      div_q <= div_d;
      start_q <= start_d;
      io_oe_q <= io_oe_d;
    end
  end

  assign system_reset = sys_rst_q;
  assign clk_ctrl = clk_q;
  assign cpu_clk_div = div_q;
  assign cpu_start = start_q;
  assign cpu_fetch_addr = RESET_VECTOR;
  assign io_output_enable = io_oe_q;

  //////////////////////////////////////////////////////////////////////////
  // secondary watchdog counter
  logic [WDT_WIDTH-1:0] wdt_q, wdt_d;

  // cleared in reset, counts on internal oscillator after release
  always_comb begin
    if (sys_rst_d) begin
      wdt_d = '0;
    end else begin
      wdt_d = wdt_q + WDT_WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wdt_q <= '0;
    end else begin
      wdt_q <= wdt_d;
    end
  end

  assign watchdog_count = wdt_q;
  assign watchdog_run = !sys_rst_q;

  //////////////////////////////////////////////////////////////////////////
  // ram validity tracking
  logic ram_ok_q, ram_ok_d;

  // lost at power-on or when an access meets reset entry
  always_comb begin
    ram_ok_d = ram_ok_q;
    if (!in_reset && sys_rst_d && cpu_access_active) begin
      ram_ok_d = 1'b0;
    end else if (phase_q == PH_RUN && cpu_access_active) begin
      ram_ok_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ram_ok_q <= 1'b0;
    end else begin
      ram_ok_q <= ram_ok_d;
    end
  end

  assign ram_contents_valid = ram_ok_q;

  //////////////////////////////////////////////////////////////////////////
  // debug control and reset cause flags
  logic [7:0] dbg_q, dbg_d;
  logic [7:0] flags_q, flags_d;
  logic wdt_entry;

  assign wdt_entry = (phase_d == PH_WDT_RESET) && (phase_q != PH_WDT_RESET);

  // pin reset rewrites both; other sources only set their flag
  always_comb begin
    dbg_d = dbg_q;
    flags_d = flags_q;
    if (phase_q == PH_PIN_RESET) begin
      dbg_d = DEBUG_CTRL_PIN_RESET;
      flags_d = CAUSE_FLAGS_PIN_RESET;
    end else begin
      if (debug_mode_enable_clear) begin
        dbg_d[0] = 1'b0;
      end
      if (cause_flags_clear_we) begin
        flags_d = flags_q & cause_flags_clear_mask;
      end
      if (wdt_entry) begin
        flags_d[WATCHDOG_RESET_FLAG_BIT] = 1'b1;
      end
      if (low_voltage_reset_event) begin
        flags_d[LOW_VOLTAGE_RESET_FLAG_BIT] = 1'b1;
      end
      if (clock_monitor_reset_event) begin
        flags_d[CLOCK_MONITOR_RESET_FLAG_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dbg_q <= DEBUG_CTRL_PIN_RESET;
      flags_q <= CAUSE_FLAGS_PIN_RESET;
    end else begin
      dbg_q <= dbg_d;
      flags_q <= flags_d;
    end
  end

  assign debug_mode_control = dbg_q;
  assign reset_cause_flags = flags_q;

endmodule // system_reset_pin_and_watchdog

`default_nettype wire

/* File: system_reset_pin_and_watchdog_bench.sv */
// bench: directed tests of the system reset sequencer
`timescale 1ns/10ps
`default_nettype none
module system_reset_pin_and_watchdog_bench;
  import rst_seq_pkg::*;
  logic clk = 0, reset = 1, go = 0, mode = 0, ovf = 0, lv = 0, cm = 0;
  logic acc = 0, we = 0, dclr = 0, pin_n, sr, st, wr, rv, oe;
  logic [7:0] low = 8'h00, mask = 8'hFF, dbg, fl;
  logic [2:0] div;
  logic [31:0] fa;
  logic [15:0] wc;
  clk_ctrl_t cc;
  int n_fail = 0, total_checks = 0;
  always #20 clk = ~clk;
  reset_source src (.clk(clk), .go(go), .low_cyc(low), .reset_pin_n(pin_n));
  system_reset_pin_and_watchdog #(.STAB_CYC(8)) uut (.clk(clk), .reset(reset),
    .reset_pin_n(pin_n), .watchdog_reset_mode(mode),
    .watchdog_overflow_reset(ovf), .low_voltage_reset_event(lv),
    .clock_monitor_reset_event(cm), .cpu_access_active(acc),
    .cause_flags_clear_mask(mask), .cause_flags_clear_we(we),
    .debug_mode_enable_clear(dclr), .system_reset(sr), .clk_ctrl(cc),
    .cpu_clk_div(div), .cpu_start(st), .cpu_fetch_addr(fa),
    .watchdog_run(wr), .watchdog_count(wc), .ram_contents_valid(rv),
    .io_output_enable(oe), .debug_mode_control(dbg), .reset_cause_flags(fl));
  ////////////////////////////////////////////////////////////////////////
  // compare, wait and finish helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_run;
    for (int i = 0; i < 200 && st !== 1'b1; i++) @(negedge clk);
    cyc(2);
  endtask
  task automatic close_out;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    cyc(6);
    reset = 0;
    wait_run;
    chk(div, 3'h3);
    chk(fa, 32'h0);
    chk(cc, 5'h1F);
    chk(oe, 1'b1);
    chk(dbg, 8'h01);
    chk(fl, 8'h00);
    chk(wr, 1'b1);
    acc = 1;
    cyc(2);
    chk(rv, 1'b1);
    low = 8'h01;
    go = 1;
    cyc(1);
    go = 0;
    cyc(8);
    chk(sr, 1'b0);
    dclr = 1; // software clears the debug enable early
    cyc(1);
    dclr = 0;
    mode = 1;
    ovf = 1;
    cyc(1);
    ovf = 0;
    cyc(2);
    chk(sr, 1'b1);
    chk(fl, 8'h10);
    chk(cc, 5'h04);
    chk(rv, 1'b0);
    chk(wr, 1'b0);
    cyc(4);
    chk(dbg, 8'h00);
    wait_run;
    chk(sr, 1'b0);
    mask = 8'h00;
    we = 1;
    lv = 1;
    cyc(1);
    we = 0;
    lv = 0;
    cm = 1;
    cyc(1);
    cm = 0;
    cyc(1);
    chk(fl, 8'h03);
    mask = 8'hFE;
    we = 1;
    cyc(1);
    we = 0;
    cyc(1);
    chk(fl, 8'h02);
    acc = 0;
    low = 8'h14;
    go = 1;
    cyc(1);
    go = 0;
    cyc(10);
    chk(sr, 1'b1);
    chk(oe, 1'b0);
    chk(wc, 16'h0);
    chk(dbg, 8'h01);
    chk(fl, 8'h00);
    wait_run;
    chk(sr, 1'b0);
    chk(rv, 1'b1);
    close_out;
  end
  // watchdog against a hang
  initial begin
    #(40 * 2000);
    n_fail++;
    close_out;
  end
endmodule // system_reset_pin_and_watchdog_bench
`default_nettype wire
